// ===== lcrf_engine_model.sv
// Behavioural protocol engine answering the register file's commands
`default_nettype none
module lcrf_engine_model
  import lcrf_pkg::*;
#(
  parameter int DLY = 20
) (
  // Clock
  input wire logic clk_i,
  // Register file side
  input wire lcrf_cmd_t cmd_i,
  output var lcrf_evt_t evt_o,
  // Events commanded by the bench
  input wire lcrf_evt_t inj_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int frame_cnt = 0;
  int wake_cnt = 0;
  logic ack_seen = 1'b0;
  initial evt_o = '0;
  // Frame and wake timers, acknowledge reply, bench events merged in
  always @(posedge clk_i) begin
    lcrf_evt_t e;
    e = inj_i;
    e.active = inj_i.active | (frame_cnt > 0);
    e.done = inj_i.done | (frame_cnt == 1);
    e.wake_sent = inj_i.wake_sent | (wake_cnt == 1);
    e.ack_taken = inj_i.ack_taken | ack_seen;
    ack_seen <= (cmd_i.ack === 1'b1);
    if (cmd_i.start === 1'b1) frame_cnt <= DLY;
    else if (frame_cnt > 0) frame_cnt <= frame_cnt - 1;
    if (cmd_i.wake === 1'b1) wake_cnt <= DLY;
    else if (wake_cnt > 0) wake_cnt <= wake_cnt - 1;
    evt_o <= e;
  end
endmodule : lcrf_engine_model
`default_nettype wire

// ===== lcrf_pkg.sv
// Package of LIN control register file constants and carriers
`default_nettype none
package lcrf_pkg;
  // Direct special-function addresses and pages
  localparam logic [7:0] ADDR_MODE = 8'hC9;
  localparam logic [7:0] PAGE_MODE = 8'h0F;
  localparam logic [7:0] ADDR_INDEX = 8'hD3;
  localparam logic [7:0] ADDR_WINDOW = 8'hD2;
  localparam logic [7:0] PAGE_LIN = 8'h00;
  // Indirect register indices
  localparam logic [7:0] IDX_DATA_LAST = 8'h07;
  localparam logic [7:0] IDX_CTRL = 8'h08;
  localparam logic [7:0] IDX_STAT = 8'h09;
  localparam logic [7:0] IDX_ERR = 8'h0A;
  localparam logic [7:0] IDX_SIZE = 8'h0B;
  localparam logic [7:0] IDX_DIV = 8'h0C;
  localparam logic [7:0] IDX_MUL = 8'h0D;
  localparam logic [7:0] IDX_ID = 8'h0E;
  // Control-mode bit positions and reset value
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_MASTER_BIT = 6;
  localparam int MODE_AUTO_BAUD_SELECT_BIT = 5;
  localparam logic [7:0] MODE_RESET = 8'h60;
  // Frame-control bit positions
  localparam int CTRL_STOP_BIT = 7;
  localparam int CTRL_SLEEP_BIT = 6;
  localparam int CTRL_DIR_BIT = 5;
  localparam int CTRL_ACK_BIT = 4;
  localparam int CTRL_CLR_IRQ_BIT = 3;
  localparam int CTRL_CLR_ERR_BIT = 2;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int CTRL_START_BIT = 0;
  // Role-restricted bit masks per register
  localparam logic [7:0] CTRL_SLV_ONLY = 8'hD0;
  localparam logic [7:0] CTRL_MST_ONLY = 8'h01;
  localparam logic [7:0] STAT_SLV_ONLY = 8'h30;
  localparam logic [7:0] ERR_SLV_ONLY = 8'h18;
  // Implemented-bit masks and reset values
  localparam logic [7:0] ID_MASK = 8'h3F;
  localparam logic [4:0] ERR_RESET = 5'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Configuration towards the protocol engine
  typedef struct packed {
    logic enable;
    logic master;
    logic auto_baud;
    logic direction;
    logic sleep;
    logic [7:0] frame_size;
    logic [7:0] divider;
    logic [7:0] multiplier;
    logic [5:0] identifier;
  } lcrf_cfg_t;
  // One-cycle command pulses towards the engine
  typedef struct packed {
    logic start;
    logic stop;
    logic ack;
    logic wake;
  } lcrf_cmd_t;
  // Events reported by the engine
  typedef struct packed {
    logic active;
    logic id_rx;
    logic done;
    logic [4:0] err_set;
    logic wake_seen;
    logic idle_to;
    logic abort;
    logic ack_taken;
    logic wake_sent;
    logic rx_we;
    logic [2:0] rx_idx;
    logic [7:0] rx_byte;
  } lcrf_evt_t;
endpackage : lcrf_pkg
`default_nettype wire

// ===== lcrf_regs.sv
// LIN control register file: direct mode register and indirect bank
// Function
// R1: Mode bit 7 disables the interface at 0, enables it at 1.
// R2: Mode bit 6 picks slave at 0, master at 1; master after reset.
// R3: Mode bit 5 picks automatic baud, effective only in slave role.
// R4: Mode bits 4 to 0 read zero and ignore writes.
// R5: Mode register sits at address 0xC9 on page 0x0F.
// R6: Fifteen indirect registers at indices 0x00 to 0x0E.
// R7: Master-only bits usable in master role, slave-only bits in slave role.
// R8: Eight data bytes at 0x00 to 0x07, sent or received, reset zero.
// R9: Slave stop bit suspends bus processing until next break; reads zero.
// R10: Slave sleep bit requests sleep; clearing it wakes after wake-up.
// R11: Control bit 5 marks frame as transmit at 1, receive at 0.
// R12: Slave acknowledge bit set by software, cleared by the controller.
// R13: Control bit 3 written 1 clears pending interrupt; reads zero.
// R14: Control bit 2 written 1 clears all error flags; reads zero.
// R15: Wake bit sends wake-up signal, then clears itself.
// R16: Master start bit starts a frame, clears at completion or error.
// R17: Software loads identifier, length and data before starting.
// R18: Index register 0xD3 and window register 0xD2 reach indirect bank.
// R19: Slave data request flag sets on identifier received, else clears.
// R20: Wrong-role writes change nothing; wrong-role bits read zero.
`default_nettype none
module lcrf_regs
  import lcrf_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // CPU special-function bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Protocol engine side
  input wire lcrf_evt_t evt_i,
  output lcrf_cfg_t cfg_o,
  output lcrf_cmd_t cmd_o,
  output logic [63:0] tx_data_o
);

  // Bits of a register usable in the given role
  function automatic logic [7:0] role_mask(input logic [7:0] idx, input logic master);
    logic [7:0] slv;
    logic [7:0] mst;
    slv = 8'h00;
    mst = 8'h00;
    case (idx)
      IDX_CTRL: begin
        slv = CTRL_SLV_ONLY;
        mst = CTRL_MST_ONLY;
      end
      IDX_STAT: slv = STAT_SLV_ONLY;
      IDX_ERR: slv = ERR_SLV_ONLY;
      default: slv = 8'h00;
    endcase
    return master ? ~slv : ~mst; // R7 R20
  endfunction : role_mask

  // State
  logic mode_en;
  logic mode_master;
  logic mode_auto_baud_select;
  logic [7:0] index;
  logic [7:0] data_mem [8];
  logic ctrl_sleep;
  logic ctrl_dir;
  logic ctrl_ack;
  logic ctrl_wake;
  logic ctrl_start;
  logic st_active;
  logic st_idle;
  logic st_abort;
  logic st_data_request_flag;
  logic st_irq;
  logic st_err;
  logic st_wake;
  logic st_done;
  logic [4:0] err_flags;
  logic [7:0] size_reg;
  logic [7:0] div_reg;
  logic [7:0] mul_reg;
  logic [5:0] id_reg;
  logic auto_baud_eff;
  logic next_mode_master;
  logic next_mode_auto_baud_select;

  // Address decode and masked write data
  logic sel_mode;
  logic sel_index;
  logic sel_window;
  logic wr_win;
  logic wr_ctrl;
  logic [7:0] wmask;
  logic [7:0] wd;
  logic do_start;
  logic do_stop;
  logic do_ack;
  logic do_wake;
  logic clr_irq;
  logic clr_err;
  logic any_event;
  logic frame_end;
  logic [7:0] rd_mux;

  assign sel_mode = (sfr_page_i == PAGE_MODE) && (sfr_addr_i == ADDR_MODE); // R5
  assign sel_index = (sfr_page_i == PAGE_LIN) && (sfr_addr_i == ADDR_INDEX); // R18
  assign sel_window = (sfr_page_i == PAGE_LIN) && (sfr_addr_i == ADDR_WINDOW); // R18
  assign wr_win = ce_i && sfr_wr_i && sel_window;
  assign wr_ctrl = wr_win && (index == IDX_CTRL);
  assign wmask = role_mask(index, mode_master);
  assign wd = sfr_wdata_i & wmask; // R20

  // Command decode: start and wake gated by enable and error state, stop and ack by enable only
  assign do_start = wr_ctrl && wd[CTRL_START_BIT] && mode_en && !st_err; // R16
  assign do_stop = wr_ctrl && wd[CTRL_STOP_BIT] && mode_en; // R9
  assign do_ack = wr_ctrl && wd[CTRL_ACK_BIT] && mode_en; // R12
  assign do_wake = wr_ctrl && wd[CTRL_WAKE_BIT] && mode_en && !st_err; // R15
  assign clr_irq = wr_ctrl && wd[CTRL_CLR_IRQ_BIT]; // R13
  assign clr_err = wr_ctrl && wd[CTRL_CLR_ERR_BIT]; // R14
  assign frame_end = evt_i.done || (|evt_i.err_set);
  assign any_event = evt_i.id_rx || frame_end || evt_i.wake_seen || evt_i.idle_to;

  // Next mode values, shared by mode and effective baud flops
  always_comb begin
    next_mode_master = mode_master;
    next_mode_auto_baud_select = mode_auto_baud_select;
    if (ce_i && sfr_wr_i && sel_mode) begin
      next_mode_master = sfr_wdata_i[MODE_MASTER_BIT]; // R2
      next_mode_auto_baud_select = sfr_wdata_i[MODE_AUTO_BAUD_SELECT_BIT]; // R3
    end
  end

  // Control-mode register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_en <= MODE_RESET[MODE_EN_BIT];
      mode_master <= MODE_RESET[MODE_MASTER_BIT];
      mode_auto_baud_select <= MODE_RESET[MODE_AUTO_BAUD_SELECT_BIT];
      auto_baud_eff <= 1'b0;
    end else if (ce_i) begin
      if (sfr_wr_i && sel_mode) begin
        mode_en <= sfr_wdata_i[MODE_EN_BIT]; // R1
      end
      mode_master <= next_mode_master;
      mode_auto_baud_select <= next_mode_auto_baud_select;
      auto_baud_eff <= next_mode_auto_baud_select && !next_mode_master; // R3
    end
  end

  // Indirect index register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      index <= REG_RESET;
    end else if (ce_i && sfr_wr_i && sel_index) begin
      index <= sfr_wdata_i; // R18
    end
  end

  // Data bytes, engine receive takes priority over CPU
  for (genvar i = 0; i < 8; i++) begin : g_data
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        data_mem[i] <= REG_RESET; // R8
      end else if (ce_i) begin
        if (evt_i.rx_we && (evt_i.rx_idx == 3'(i))) begin
          data_mem[i] <= evt_i.rx_byte; // R8
        end else if (wr_win && (index == 8'(i))) begin
          data_mem[i] <= sfr_wdata_i; // R8
        end
      end
    end
    assign tx_data_o[8*i +: 8] = data_mem[i];
  end

  // Frame-control stored bits
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_sleep <= 1'b0;
      ctrl_dir <= 1'b0;
    end else if (ce_i && wr_ctrl) begin
      if (!mode_master) begin
        ctrl_sleep <= wd[CTRL_SLEEP_BIT]; // R10
      end
      ctrl_dir <= wd[CTRL_DIR_BIT]; // R11
    end
  end

  // Self-clearing request bits; software set wins over clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_ack <= 1'b0;
      ctrl_wake <= 1'b0;
      ctrl_start <= 1'b0;
    end else if (ce_i) begin
      if (do_ack) begin
        ctrl_ack <= 1'b1; // R12
      end else if (evt_i.ack_taken) begin
        ctrl_ack <= 1'b0; // R12
      end
      if (do_wake) begin
        ctrl_wake <= 1'b1; // R15
      end else if (evt_i.wake_sent || (|evt_i.err_set)) begin
        ctrl_wake <= 1'b0; // R15
      end
      if (do_start) begin
        ctrl_start <= 1'b1; // R16
      end else if (frame_end) begin
        ctrl_start <= 1'b0; // R16
      end
    end
  end

  // Command pulses to the engine
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_o <= '0;
    end else if (ce_i) begin
      cmd_o.start <= do_start; // R16
      cmd_o.stop <= do_stop; // R9
      cmd_o.ack <= do_ack; // R12
      cmd_o.wake <= do_wake; // R15
    end
  end

  // Status flags; hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_active <= 1'b0;
      st_idle <= 1'b0;
      st_abort <= 1'b0;
      st_data_request_flag <= 1'b0;
      st_irq <= 1'b0;
      st_wake <= 1'b0;
      st_done <= 1'b0;
    end else if (ce_i) begin
      st_active <= evt_i.active;
      if (evt_i.idle_to) begin
        st_idle <= 1'b1;
      end else if (evt_i.active) begin
        st_idle <= 1'b0;
      end
      if (evt_i.abort || do_stop) begin
        st_abort <= 1'b1;
      end else if (evt_i.id_rx) begin
        st_abort <= 1'b0;
      end
      if (evt_i.id_rx && !mode_master) begin
        st_data_request_flag <= 1'b1; // R19
      end else if (do_ack || do_stop || frame_end || mode_master) begin
        st_data_request_flag <= 1'b0; // R19
      end
      if (any_event) begin
        st_irq <= 1'b1;
      end else if (clr_irq) begin
        st_irq <= 1'b0; // R13
      end
      if (evt_i.wake_seen || do_wake) begin
        st_wake <= 1'b1;
      end else if (do_start) begin
        st_wake <= 1'b0;
      end
      if (evt_i.done || evt_i.wake_seen) begin
        st_done <= 1'b1;
      end else if (do_start) begin
        st_done <= 1'b0;
      end
    end
  end

  // Error flags and summary; new error wins over clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      err_flags <= ERR_RESET;
      st_err <= 1'b0;
    end else if (ce_i) begin
      if (|evt_i.err_set) begin
        err_flags <= (clr_err ? ERR_RESET : err_flags) | evt_i.err_set;
        st_err <= 1'b1;
      end else if (clr_err) begin
        err_flags <= ERR_RESET; // R14
        st_err <= 1'b0; // R14
      end
    end
  end

  // Size, baud and identifier registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      size_reg <= REG_RESET;
      div_reg <= REG_RESET;
      mul_reg <= REG_RESET;
      id_reg <= '0;
    end else if (wr_win) begin
      case (index)
        IDX_SIZE: size_reg <= sfr_wdata_i;
        IDX_DIV: div_reg <= sfr_wdata_i;
        IDX_MUL: mul_reg <= sfr_wdata_i;
        IDX_ID: id_reg <= sfr_wdata_i[5:0];
        default: id_reg <= id_reg;
      endcase
    end
  end

  // Read multiplexer for all mapped locations
  always_comb begin
    rd_mux = 8'h00;
    if (sel_mode) begin
      rd_mux = {mode_en, mode_master, mode_auto_baud_select, 5'b00000}; // R4
    end else if (sel_index) begin
      rd_mux = index;
    end else if (sel_window) begin
      case (index)
        IDX_CTRL: rd_mux = {1'b0, ctrl_sleep, ctrl_dir, ctrl_ack, 2'b00, ctrl_wake,
                            ctrl_start}; // R9 R13 R14
        IDX_STAT: rd_mux = {st_active, st_idle, st_abort, st_data_request_flag, st_irq, st_err,
                            st_wake, st_done};
        IDX_ERR: rd_mux = {3'b000, err_flags};
        IDX_SIZE: rd_mux = size_reg;
        IDX_DIV: rd_mux = div_reg;
        IDX_MUL: rd_mux = mul_reg;
        IDX_ID: rd_mux = {2'b00, id_reg} & ID_MASK;
        default: rd_mux = (index <= IDX_DATA_LAST) ? data_mem[index[2:0]] : 8'h00; // R6
      endcase
      rd_mux = rd_mux & role_mask(index, mode_master); // R20
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (ce_i && sfr_rd_i) begin
      sfr_rdata_o <= rd_mux;
    end
  end

  // Configuration to the engine, all from flops
  assign cfg_o.enable = mode_en; // R1
  assign cfg_o.master = mode_master; // R2
  assign cfg_o.auto_baud = auto_baud_eff; // R3
  assign cfg_o.direction = ctrl_dir; // R11
  assign cfg_o.sleep = ctrl_sleep; // R10
  assign cfg_o.frame_size = size_reg;
  assign cfg_o.divider = div_reg;
  assign cfg_o.multiplier = mul_reg;
  assign cfg_o.identifier = id_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Control register write with a given bit set
  sequence s_ctrl_set(int b);
    wr_ctrl && sfr_wdata_i[b];
  endsequence

  property p_mode_low_zero;
    ce_i && sfr_rd_i && sel_mode |=> sfr_rdata_o[4:0] == 5'b00000;
  endproperty
  a_mode_low_zero: assert property (p_mode_low_zero) // R4
    else $error("mode low bits not zero");

  property p_enable_follows;
    ce_i && sfr_wr_i && sel_mode |=> cfg_o.enable == $past(sfr_wdata_i[MODE_EN_BIT]);
  endproperty
  a_enable_follows: assert property (p_enable_follows) // R1
    else $error("enable does not follow write");

  property p_auto_baud_select_slave;
    cfg_o.auto_baud |-> !cfg_o.master && mode_auto_baud_select;
  endproperty
  a_auto_baud_select_slave: assert property (p_auto_baud_select_slave) // R3
    else $error("auto baud active in master role");

  property p_start_master;
    s_ctrl_set(CTRL_START_BIT) ##0 (mode_master && mode_en && !st_err)
      |=> cmd_o.start && ctrl_start;
  endproperty
  a_start_master: assert property (p_start_master) // R16
    else $error("start request not issued");

  property p_start_role;
    cmd_o.start |-> $past(mode_master);
  endproperty
  a_start_role: assert property (p_start_role) // R7
    else $error("start issued in slave role");

  property p_start_ends;
    ce_i && frame_end && !do_start |=> !ctrl_start;
  endproperty
  a_start_ends: assert property (p_start_ends) // R16
    else $error("start bit not cleared at frame end");

  property p_clear_irq;
    s_ctrl_set(CTRL_CLR_IRQ_BIT) ##0 !any_event |=> !st_irq;
  endproperty
  a_clear_irq: assert property (p_clear_irq) // R13
    else $error("interrupt flag not cleared");

  property p_clear_err;
    s_ctrl_set(CTRL_CLR_ERR_BIT) ##0 (evt_i.err_set == 5'b00000)
      |=> !st_err && (err_flags == ERR_RESET);
  endproperty
  a_clear_err: assert property (p_clear_err) // R14
    else $error("error flags not cleared");

  property p_data_request_flag;
    ce_i && evt_i.id_rx && !mode_master |=> st_data_request_flag;
  endproperty
  a_data_request_flag: assert property (p_data_request_flag) // R19
    else $error("data request not raised");

  property p_ctrl_read;
    ce_i && sfr_rd_i && sel_window && (index == IDX_CTRL)
      |=> sfr_rdata_o[7] == 1'b0 && sfr_rdata_o[3:2] == 2'b00;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) // R9
    else $error("write-only control bits read nonzero");

  property p_stop_slave;
    cmd_o.stop |-> !$past(mode_master) && st_abort;
  endproperty
  a_stop_slave: assert property (p_stop_slave) // R20
    else $error("stop issued in master role");

endmodule : lcrf_regs
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the LIN control register file
`default_nettype none
module tb_top
  import lcrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 20;
  // Design signals
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_page_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  lcrf_evt_t evt;
  lcrf_evt_t inj = '0;
  lcrf_cfg_t cfg_o;
  lcrf_cmd_t cmd_o;
  logic [63:0] tx_data_o;
  // Bench model, counters, scratch
  int mdl_data [8];
  int n_start = 0;
  int n_stop = 0;
  int n_ack = 0;
  int n_wake = 0;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [7:0] v;
  logic [7:0] r;
  logic [7:0] mv [2] = '{8'hBF, 8'h7F};
  lcrf_evt_t e;

  lcrf_regs dut_u (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .sfr_addr_i(sfr_addr_i),
    .sfr_page_i(sfr_page_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .evt_i(evt), .cfg_o(cfg_o),
    .cmd_o(cmd_o), .tx_data_o(tx_data_o));
  lcrf_engine_model #(.DLY(DLY)) eng_u (.clk_i(clk_i), .cmd_i(cmd_o), .evt_o(evt),
    .inj_i(inj));

  // Clock generator
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Command pulse counters, sampled mid-cycle
  always @(negedge clk_i) begin
    if (cmd_o.start === 1'b1) n_start++;
    if (cmd_o.stop === 1'b1) n_stop++;
    if (cmd_o.ack === 1'b1) n_ack++;
    if (cmd_o.wake === 1'b1) n_wake++;
  end

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check8

  task automatic checkn(input string name, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
    end
  endtask : checkn

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_page_i = p;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, input logic [7:0] p, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_page_i = p;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask : sfr_read

  task automatic ind_write(input logic [7:0] idx, input logic [7:0] d);
    sfr_write(ADDR_INDEX, PAGE_LIN, idx);
    sfr_write(ADDR_WINDOW, PAGE_LIN, d);
  endtask : ind_write

  task automatic ind_read(input logic [7:0] idx, output logic [7:0] d);
    sfr_write(ADDR_INDEX, PAGE_LIN, idx);
    sfr_read(ADDR_WINDOW, PAGE_LIN, d);
  endtask : ind_read

  task automatic ind_check(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    ind_read(idx, d);
    check8(name, exp, d);
  endtask : ind_check

  task automatic inject(input lcrf_evt_t ev);
    @(negedge clk_i);
    inj = ev;
    @(negedge clk_i);
    inj = '0;
    repeat (2) @(negedge clk_i);
  endtask : inject

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog against a hung run
  initial begin
    #100us;
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(67));
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    // Reset values, refused places
    sfr_read(ADDR_MODE, PAGE_MODE, r);
    check8("mode reset", MODE_RESET, r);
    for (int i = 0; i < 16; i++) ind_check("reset bank", 8'(i), 8'h00);
    sfr_read(ADDR_MODE, PAGE_LIN, r);
    check8("mode wrong page", 8'h00, r);
    sfr_read(8'h55, PAGE_LIN, r);
    check8("unmapped", 8'h00, r);
    // Mode register fields
    for (int i = 0; i < 4; i++) begin
      v = (i < 2) ? mv[i] : 8'($urandom);
      sfr_write(ADDR_MODE, PAGE_MODE, v);
      sfr_read(ADDR_MODE, PAGE_MODE, r);
      check8("mode", v & 8'hE0, r);
      check8("enable", {7'h00, v[7]}, {7'h00, cfg_o.enable});
      check8("master", {7'h00, v[6]}, {7'h00, cfg_o.master});
      check8("auto baud", {7'h00, v[5] & ~v[6]}, {7'h00, cfg_o.auto_baud});
    end
    // Data bytes through the window
    sfr_write(ADDR_MODE, PAGE_MODE, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      mdl_data[i] = $urandom % 256;
      ind_write(8'(i), 8'(mdl_data[i]));
    end
    for (int i = 0; i < 8; i++) begin
      ind_check("data byte", 8'(i), 8'(mdl_data[i]));
      check8("tx byte", 8'(mdl_data[i]), tx_data_o[8*i +: 8]);
    end
    // Frozen clock enable drops a write
    ce_i = 1'b0;
    sfr_write(ADDR_WINDOW, PAGE_LIN, ~8'(mdl_data[7]));
    ce_i = 1'b1;
    ind_check("frozen write", 8'h07, 8'(mdl_data[7]));
    // Frame setup: identifier and size
    v = 8'($urandom);
    ind_write(IDX_ID, v);
    ind_write(IDX_SIZE, 8'h84);
    ind_check("identifier", IDX_ID, v & ID_MASK);
    ind_check("size", IDX_SIZE, 8'h84);
    check8("cfg id", v & ID_MASK, {2'b00, cfg_o.identifier});
    // Baud registers and their configuration outputs, then master start
    ind_write(IDX_DIV, v);
    ind_write(IDX_MUL, ~v);
    ind_check("divider", IDX_DIV, v);
    ind_check("multiplier", IDX_MUL, ~v);
    check8("cfg size", 8'h84, cfg_o.frame_size);
    check8("cfg divider", v, cfg_o.divider);
    check8("cfg multiplier", ~v, cfg_o.multiplier);
    ind_write(IDX_CTRL, 8'h01);
    ind_check("ctrl busy", IDX_CTRL, 8'h01);
    repeat (DLY + 4) @(negedge clk_i);
    checkn("start pulses", 1, n_start);
    ind_check("ctrl done", IDX_CTRL, 8'h00);
    ind_check("status done", IDX_STAT, 8'h09);
    ind_write(IDX_CTRL, 8'h08);
    ind_check("status irq cleared", IDX_STAT, 8'h01);
    ind_check("ctrl clear reads", IDX_CTRL, 8'h00);
    // Errors in master role, start refused while flagged
    e = '0;
    e.err_set = 5'h1F;
    inject(e);
    ind_check("error flags", IDX_ERR, 8'h07);
    ind_read(IDX_STAT, r);
    check8("status error", 8'h0C, r & 8'h0C);
    ind_write(IDX_CTRL, 8'h01);
    repeat (3) @(negedge clk_i);
    checkn("start refused", 1, n_start);
    ind_write(IDX_CTRL, 8'h04);
    ind_check("errors cleared", IDX_ERR, 8'h00);
    ind_read(IDX_STAT, r);
    check8("status error cleared", 8'h00, r & 8'h04);
    ind_write(IDX_CTRL, 8'h08);
    // Slave: data request and acknowledge
    sfr_write(ADDR_MODE, PAGE_MODE, 8'h80);
    e = '0;
    e.id_rx = 1'b1;
    inject(e);
    ind_read(IDX_STAT, r);
    check8("data request", 8'h18, r & 8'h18);
    ind_write(IDX_CTRL, 8'h11);
    repeat (3) @(negedge clk_i);
    checkn("ack pulses", 1, n_ack);
    checkn("start in slave", 1, n_start);
    ind_check("ack self clear", IDX_CTRL, 8'h00);
    ind_read(IDX_STAT, r);
    check8("request cleared", 8'h00, r & 8'h10);
    // Sleep, direction, stop
    ind_write(IDX_CTRL, 8'h60);
    ind_check("sleep dir", IDX_CTRL, 8'h60);
    check8("cfg dir sleep", 8'h03, {6'h00, cfg_o.direction, cfg_o.sleep});
    ind_write(IDX_CTRL, 8'hE0);
    ind_check("stop reads zero", IDX_CTRL, 8'h60);
    checkn("stop pulses", 1, n_stop);
    ind_read(IDX_STAT, r);
    check8("abort", 8'h20, r & 8'h20);
    // Idle timeout and wake-up seen from the bus
    e = '0;
    e.idle_to = 1'b1;
    e.wake_seen = 1'b1;
    inject(e);
    ind_read(IDX_STAT, r);
    check8("idle wake done", 8'h43, r & 8'h43);
    ind_write(IDX_CTRL, 8'h62);
    ind_check("wake pending", IDX_CTRL, 8'h62);
    repeat (DLY + 4) @(negedge clk_i);
    ind_check("wake self clear", IDX_CTRL, 8'h60);
    checkn("wake pulses", 1, n_wake);
    sfr_write(ADDR_MODE, PAGE_MODE, 8'hC0);
    ind_check("slave bits hidden", IDX_CTRL, 8'h20);
    // Received byte from the engine
    e = '0;
    e.rx_we = 1'b1;
    e.rx_idx = 3'd3;
    e.rx_byte = 8'($urandom);
    mdl_data[3] = e.rx_byte;
    inject(e);
    ind_check("rx byte", 8'h03, 8'(mdl_data[3]));
    // Disabled interface ignores commands
    sfr_write(ADDR_MODE, PAGE_MODE, 8'h40);
    ind_write(IDX_CTRL, 8'h02);
    repeat (3) @(negedge clk_i);
    checkn("wake disabled", 1, n_wake);
    check8("cfg disabled", 8'h00, {7'h00, cfg_o.enable});
    // Second reset in mid-run restores defaults
    @(negedge clk_i);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    sfr_read(ADDR_MODE, PAGE_MODE, r);
    check8("mode after reset", MODE_RESET, r);
    check8("auto baud after reset", 8'h00, {7'h00, cfg_o.auto_baud});
    ind_check("data after reset", 8'h03, 8'h00);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
